/* File: logic/sac_conversion_control.sv */
// converter control: registers, prescaler, triggering, sar sequencing, result latching
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns

// Function
// - ten-bit result, zero is ground
// - reference chosen by reference select field
// - input chosen by channel select field
// - selections apply only while converter enabled
// - right aligned default, left when bit set
// - low byte read blocks result updates
// - high byte read lifts the block
// - blocked result still sets done flag
// - start bit begins conversion, self clears
// - channel change waits for conversion end
// - auto trigger uses selected trigger source
// - trigger edge resets prescaler, starts conversion
// - held trigger level starts nothing new
// - trigger edges during conversion are ignored
// - done flag trigger gives free running
// - free run first start by start bit
// - start bit works and reads busy always
// - dedicated done interrupt when enabled
// - thirteen clocks, first after enable twentyfive
// - prescaler runs only while enabled
// - completion writes result, sets flag, clears start outside free run
// - selections frozen until last conversion clock
module sac_conversion_control (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic doneIrq,
  input wire logic irqServiced,
  // trigger sources 1..7
  input wire logic [7:1] trigIn,
  // analog core
  output logic analogEnable,
  output logic [1:0] refSelOut,
  output logic [3:0] chanSelOut,
  output logic sampleHold,
  output logic [9:0] dacCode,
  input wire logic cmpIn
);
  import sac_pkg::*;

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [1:0] refSel_reg;
  logic [3:0] chanSel_reg;
  logic leftAlign_reg, enable_reg, autoTrig_reg, doneFlag_reg, irqEn_reg, powerGate_reg;
  logic [2:0] prescale_reg, trigSel_reg;
  logic [7:0] resLow_reg, resHigh_reg;
  logic lock_reg, firstConv_reg, trigPrev_reg, inBits_reg;
  logic [6:0] presCnt_reg;
  logic [4:0] convCnt_reg;
  logic [9:0] sar_reg;
  logic [3:0] bitPos_reg;
  sac_state_t state_reg;

  logic busAccess, wrCommit, rdCommit, wrLane0, startWrite, doneClearWrite, loRead, hiRead;
  logic [7:0] rdByte;
  logic enEff, convTick, lastCyc, completing, presClr, loBusy;
  logic [4:0] convLen, sampleAt;
  logic [9:0] sarFinal;
  logic trigSrc, trigEdge, freeRun;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] base);
    hit = (adr[7:2] == base[7:2]);
  endfunction
  function automatic logic [6:0] ratioLimit(input logic [2:0] ps);
    // smallest division is two; code zero and one both divide by two
    ratioLimit = (ps == 3'h0) ? 7'h01 : 7'((8'h01 << ps) - 8'h01);
  endfunction

  // ----------------------------------------
  // bus slave: one wait state, writes and read side effects at the ack edge
  // ----------------------------------------
  assign busAccess = wb_cyc_i && wb_stb_i;
  assign wrCommit = busAccess && wb_ack_o && wb_we_i;
  assign rdCommit = busAccess && wb_ack_o && !wb_we_i;
  assign wrLane0 = wrCommit && wb_sel_i[0];
  assign startWrite = wrLane0 && hit(wb_adr_i, ADDR_CTRL_A) && wb_dat_i[START_BIT];
  assign doneClearWrite = wrLane0 && hit(wb_adr_i, ADDR_CTRL_A) && wb_dat_i[DONE_FLAG_BIT];
  assign loRead = rdCommit && hit(wb_adr_i, ADDR_RES_LOW);
  assign hiRead = rdCommit && hit(wb_adr_i, ADDR_RES_HIGH);
  // the low byte is latched a cycle before the block sets, so a read in flight blocks too
  assign loBusy = busAccess && !wb_we_i && hit(wb_adr_i, ADDR_RES_LOW);

  always_comb begin
    rdByte = 8'h00;
    if (hit(wb_adr_i, ADDR_INPUT_SEL)) begin
      rdByte = {refSel_reg, leftAlign_reg, 1'b0, chanSel_reg};
    end else if (hit(wb_adr_i, ADDR_CTRL_A)) begin
      rdByte = {enable_reg, state_reg != SAC_IDLE, autoTrig_reg, doneFlag_reg,
                irqEn_reg, prescale_reg};
    end else if (hit(wb_adr_i, ADDR_CTRL_B)) begin
      rdByte = {5'h00, trigSel_reg};
    end else if (hit(wb_adr_i, ADDR_RES_LOW)) begin
      rdByte = resLow_reg;
    end else if (hit(wb_adr_i, ADDR_RES_HIGH)) begin
      rdByte = resHigh_reg;
    end else if (hit(wb_adr_i, ADDR_POWER)) begin
      rdByte = {7'h00, powerGate_reg};
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busAccess && !wb_ack_o;
      if (busAccess && !wb_ack_o) begin
        wb_dat_o <= {24'h00_0000, rdByte};
      end
    end
  end

  // software-written configuration
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {refSel_reg, leftAlign_reg, chanSel_reg} <= {INPUT_SEL_RESET[7:5], INPUT_SEL_RESET[3:0]};
      enable_reg <= 1'b0;
      autoTrig_reg <= 1'b0;
      irqEn_reg <= 1'b0;
      prescale_reg <= PRESCALE_RESET;
      trigSel_reg <= TRIG_SEL_RESET;
      powerGate_reg <= POWER_GATE_RESET;
    end else if (wrLane0) begin
      if (hit(wb_adr_i, ADDR_INPUT_SEL)) begin
        refSel_reg <= wb_dat_i[REF_SEL_LSB +: 2];
        leftAlign_reg <= wb_dat_i[LEFT_ALIGN_BIT];
        chanSel_reg <= wb_dat_i[CHAN_SEL_LSB +: 4];
      end
      if (hit(wb_adr_i, ADDR_CTRL_A)) begin
        enable_reg <= wb_dat_i[ENABLE_BIT];
        autoTrig_reg <= wb_dat_i[AUTO_TRIG_BIT];
        irqEn_reg <= wb_dat_i[IRQ_EN_BIT];
        prescale_reg <= wb_dat_i[PRESCALE_LSB +: 3];
      end
      if (hit(wb_adr_i, ADDR_CTRL_B)) begin
        trigSel_reg <= wb_dat_i[TRIG_SEL_LSB +: 3];
      end
      if (hit(wb_adr_i, ADDR_POWER)) begin
        powerGate_reg <= wb_dat_i[POWER_GATE_BIT];
      end
    end
  end

  // a gated converter behaves as disabled whatever the enable bit says
  assign enEff = enable_reg && !powerGate_reg;
  assign analogEnable = enEff;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  assign convTick = enEff && (presCnt_reg >= ratioLimit(prescale_reg));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      presCnt_reg <= 7'h00;
    end else if (!enEff || presClr || convTick) begin
      presCnt_reg <= 7'h00;
    end else begin
      presCnt_reg <= presCnt_reg + 7'h01;
    end
  end

  // ----------------------------------------
  // triggering and sequencing
  // ----------------------------------------
  assign freeRun = autoTrig_reg && (trigSel_reg == TRIG_FREE_RUN);
  assign trigSrc = (trigSel_reg == TRIG_FREE_RUN) ? 1'b0 : trigIn[trigSel_reg];
  // only a fresh edge counts, a level held high starts nothing
  assign trigEdge = trigSrc && !trigPrev_reg;
  assign presClr = autoTrig_reg && trigEdge && state_reg == SAC_IDLE && enEff;
  assign convLen = firstConv_reg ? CONV_LEN_FIRST : CONV_LEN_NORMAL;
  assign sampleAt = firstConv_reg ? SAMPLE_AT_FIRST : SAMPLE_AT_NORMAL;
  assign lastCyc = state_reg == SAC_CONV && convCnt_reg == convLen - 5'h01;
  assign completing = lastCyc && convTick;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trigPrev_reg <= 1'b0;
    end else begin
      trigPrev_reg <= trigSrc;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= SAC_IDLE;
    end else if (!enEff) begin
      state_reg <= SAC_IDLE;
    end else begin
      unique case (state_reg)
        SAC_IDLE: begin
          if (startWrite || presClr) begin
            state_reg <= SAC_ARMED;
          end
        end
        SAC_ARMED: begin
          if (convTick) begin
            state_reg <= SAC_CONV;
          end
        end
        SAC_CONV: begin
          if (completing) begin
            state_reg <= (freeRun || startWrite) ? SAC_ARMED : SAC_IDLE;
          end
        end
        default: state_reg <= SAC_IDLE;
      endcase
    end
  end
  // the long first conversion follows every switch-on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      firstConv_reg <= 1'b1;
    end else if (!enEff) begin
      firstConv_reg <= 1'b1;
    end else if (completing) begin
      firstConv_reg <= 1'b0;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      convCnt_reg <= 5'h00;
    end else if (state_reg != SAC_CONV) begin
      convCnt_reg <= 5'h00;
    end else if (convTick) begin
      convCnt_reg <= convCnt_reg + 5'h01;
    end
  end

  // ----------------------------------------
  // successive approximation
  // ----------------------------------------
  assign sampleHold = state_reg == SAC_CONV && convTick && convCnt_reg == sampleAt;
  assign dacCode = sar_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sar_reg <= 10'h000;
      bitPos_reg <= 4'h0;
      inBits_reg <= 1'b0;
    end else if (sampleHold) begin
      sar_reg <= SAR_FIRST_TRIAL;
      bitPos_reg <= 4'h9;
      inBits_reg <= 1'b1;
    end else if (inBits_reg && convTick) begin
      if (!cmpIn) begin
        sar_reg[bitPos_reg] <= 1'b0;
      end
      if (bitPos_reg != 4'h0) begin
        sar_reg[bitPos_reg - 4'h1] <= 1'b1;
        bitPos_reg <= bitPos_reg - 4'h1;
      end else begin
        inBits_reg <= 1'b0;
      end
    end
  end
  assign sarFinal = sar_reg;

  // ----------------------------------------
  // selection latching toward the analog core
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refSelOut <= INPUT_SEL_RESET[7:6];
      chanSelOut <= INPUT_SEL_RESET[3:0];
    end else if (enEff && (state_reg != SAC_CONV || lastCyc)) begin
      refSelOut <= refSel_reg;
      chanSelOut <= chanSel_reg;
    end
  end

  // ----------------------------------------
  // results, blocking and completion flag
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lock_reg <= 1'b0;
    end else if (loRead) begin
      lock_reg <= 1'b1;
    end else if (hiRead) begin
      lock_reg <= 1'b0;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resLow_reg <= 8'h00;
      resHigh_reg <= 8'h00;
    end else if (completing && !lock_reg && !loBusy) begin
      if (leftAlign_reg) begin
        resHigh_reg <= sarFinal[9:2];
        resLow_reg <= {sarFinal[1:0], 6'h00};
      end else begin
        resHigh_reg <= {6'h00, sarFinal[9:8]};
        resLow_reg <= sarFinal[7:0];
      end
    end
  end
  // a completion in the same cycle as a clear keeps the flag set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      doneFlag_reg <= 1'b0;
    end else if (completing) begin
      doneFlag_reg <= 1'b1;
    end else if (doneClearWrite || irqServiced) begin
      doneFlag_reg <= 1'b0;
    end
  end

  assign doneIrq = doneFlag_reg && irqEn_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_start_reads_busy: assert property (@(posedge clock) disable iff (rst)
    state_reg == SAC_CONV |-> rdByte[START_BIT] || !hit(wb_adr_i, ADDR_CTRL_A))
    else $error("start bit not shown during conversion");
  a_done_sets_flag: assert property (@(posedge clock) disable iff (rst)
    completing |=> doneFlag_reg)
    else $error("completion did not set done flag");
  a_lock_holds_result: assert property (@(posedge clock) disable iff (rst)
    completing && lock_reg |=> $stable(resLow_reg) && $stable(resHigh_reg))
    else $error("blocked result bytes changed");
  a_high_read_unlocks: assert property (@(posedge clock) disable iff (rst)
    hiRead |=> !lock_reg)
    else $error("high byte read left block set");
  a_select_frozen: assert property (@(posedge clock) disable iff (rst)
    state_reg == SAC_CONV && !lastCyc |=> $stable(chanSelOut) && $stable(refSelOut))
    else $error("selection moved during conversion");
  a_disabled_no_update: assert property (@(posedge clock) disable iff (rst)
    !enEff |=> $stable(chanSelOut))
    else $error("selection applied while disabled");
  a_irq_on_done: assert property (@(posedge clock) disable iff (rst)
    completing && irqEn_reg && !(wrLane0 && hit(wb_adr_i, ADDR_CTRL_A)) |=> doneIrq)
    else $error("no interrupt after completion");
  a_trigger_ignored: assert property (@(posedge clock) disable iff (rst)
    state_reg == SAC_CONV && !completing && enEff && trigEdge |=> state_reg == SAC_CONV)
    else $error("trigger disturbed a running conversion");
  a_prescaler_held: assert property (@(posedge clock) disable iff (rst)
    !enEff |=> presCnt_reg == 7'h00 && !convTick)
    else $error("prescaler ran while disabled");
  a_free_run_rearm: assert property (@(posedge clock) disable iff (rst)
    completing && freeRun && enEff |=> state_reg == SAC_ARMED ##[1:256] state_reg == SAC_CONV)
    else $error("free running did not restart");
  a_normal_length: assert property (@(posedge clock) disable iff (rst)
    completing && !firstConv_reg |-> convCnt_reg == 5'h0c)
    else $error("normal conversion length wrong");
  a_left_align: assert property (@(posedge clock) disable iff (rst)
    completing && !lock_reg && leftAlign_reg |=> resHigh_reg == $past(sarFinal[9:2]))
    else $error("left aligned high byte wrong");

endmodule

/* File: logic/sac_pkg.sv */
// shared constants for the converter control block
package sac_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_INPUT_SEL = 8'h00;
  localparam logic [7:0] ADDR_CTRL_A = 8'h04;
  localparam logic [7:0] ADDR_CTRL_B = 8'h08;
  localparam logic [7:0] ADDR_RES_LOW = 8'h0c;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
  localparam logic [7:0] ADDR_POWER = 8'h14;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int REF_SEL_LSB = 6;
  localparam int LEFT_ALIGN_BIT = 5;
  localparam int CHAN_SEL_LSB = 0;
  localparam int ENABLE_BIT = 7;
  localparam int START_BIT = 6;
  localparam int AUTO_TRIG_BIT = 5;
  localparam int DONE_FLAG_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int PRESCALE_LSB = 0;
  localparam int TRIG_SEL_LSB = 0;
  localparam int POWER_GATE_BIT = 0;

  // ----------------------------------------
  // reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
  localparam logic [2:0] TRIG_SEL_RESET = 3'h0;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic POWER_GATE_RESET = 1'b1;
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h3;

  // ----------------------------------------
  // conversion timing in converter clocks
  // ----------------------------------------
  localparam logic [4:0] CONV_LEN_NORMAL = 5'h0d;
  localparam logic [4:0] CONV_LEN_FIRST = 5'h19;
  localparam logic [4:0] SAMPLE_AT_NORMAL = 5'h01;
  localparam logic [4:0] SAMPLE_AT_FIRST = 5'h0d;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;

  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_ARMED = 3'b010,
    SAC_CONV = 3'b100
  } sac_state_t;

endpackage

/* File: test/sac_analog_model.sv */
// behavioural analog core: channel mux, reference shift, sample and hold, comparator
`timescale 1ns/1ns
module sac_analog_model (
  // clock
  input wire logic clock,
  // level on every channel, as a code
  input wire logic [15:0][9:0] vinCode,
  // core controls
  input wire logic analogEnable,
  input wire logic [1:0] refSelOut,
  input wire logic [3:0] chanSelOut,
  input wire logic sampleHold,
  input wire logic [9:0] dacCode,
  // comparator
  output logic cmpIn
);
  logic [9:0] heldCode = 10'h000;
  logic cmpLast = 1'b0;
  // each reference step shifts the code by a quarter scale, so a wrong reference shows
  always_ff @(posedge clock) begin
    if (sampleHold) begin
      heldCode <= vinCode[chanSelOut] + {refSelOut, 8'h00};
    end
    cmpLast <= cmpIn;
  end
  // an unpowered core toggles, so nothing can lean on a stale level
  assign cmpIn = analogEnable ? (heldCode >= dacCode) : ~cmpLast;
endmodule

/* File: test/tb_sac_conversion_control.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_sac_conversion_control;
  import sac_pkg::*;
  localparam logic [7:0] CTL_ON = 8'h88;
  localparam logic [7:0] CTL_GO = 8'hc8;
  localparam logic [7:0] CTL_CLR = 8'h98;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck, doneIrq, analogEnable, sampleHold, cmpIn;
  logic irqServiced = 1'b0;
  logic [7:1] trigIn = 7'h00;
  logic [1:0] refSelOut;
  logic [3:0] chanSelOut;
  logic [9:0] dacCode;
  logic [15:0][9:0] vinCode = '0;
  logic [7:0] rd, selNow;
  logic [1:0] refTab [3] = '{REF_EXTERNAL, REF_SUPPLY, REF_INTERNAL};
  int err_count = 0;
  int check_count = 0;
  int holdCount = 0;
  int cycNum = 0;
  int expQ[$];
  int l1, l2, h;

  sac_conversion_control sac_conversion_control_inst (.clock(clock), .rst(rst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(4'h1), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .doneIrq(doneIrq), .irqServiced(irqServiced), .trigIn(trigIn),
    .analogEnable(analogEnable), .refSelOut(refSelOut), .chanSelOut(chanSelOut),
    .sampleHold(sampleHold), .dacCode(dacCode), .cmpIn(cmpIn));
  sac_analog_model sac_analog_model_inst (.clock(clock), .vinCode(vinCode),
    .analogEnable(analogEnable), .refSelOut(refSelOut), .chanSelOut(chanSelOut),
    .sampleHold(sampleHold), .dacCode(dacCode), .cmpIn(cmpIn));

  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycNum <= cycNum + 1;
    if (sampleHold === 1'b1) holdCount <= holdCount + 1;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= {24'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdReg(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask

  function automatic int expOf(input logic [7:0] s);
    return int'((vinCode[s[3:0]] + {s[7:6], 8'h00}) & 10'h3ff);
  endfunction

  task automatic waitDone();
    int n;
    n = 0;
    while (doneIrq !== 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 2000) err_count++;
  endtask

  task automatic checkResult(input logic align);
    int e;
    logic [7:0] lo;
    e = expQ.pop_front();
    rdReg(ADDR_RES_LOW);
    lo = rd;
    rdReg(ADDR_RES_HIGH);
    if (align) check({rd, lo}, {e[9:0], 6'h00});
    else check({rd, lo}, {6'h00, e[9:0]});
  endtask

  task automatic convert(input logic [7:0] sel);
    expQ.push_back(expOf(sel));
    wr(ADDR_INPUT_SEL, sel);
    wr(ADDR_CTRL_A, CTL_GO);
    rdReg(ADDR_CTRL_A);
    check(rd[START_BIT], 1'b1);
    waitDone();
    rdReg(ADDR_CTRL_A);
    check(rd[7:3], 5'h13);
    wr(ADDR_CTRL_A, CTL_CLR);
    @(negedge clock);
    check(doneIrq, 1'b0);
  endtask

  // a second edge mid-conversion and a held level must start nothing more
  task automatic trigConv(input int idx, output int len);
    int n, hc;
    hc = holdCount;
    expQ.push_back(expOf(selNow));
    @(posedge clock);
    trigIn[idx] <= 1'b1;
    n = cycNum;
    repeat (10) @(posedge clock);
    trigIn[idx] <= 1'b0;
    repeat (2) @(posedge clock);
    trigIn[idx] <= 1'b1;
    waitDone();
    len = cycNum - n;
    repeat (60) @(posedge clock);
    check(16'(holdCount - hc), 16'h1);
    trigIn[idx] <= 1'b0;
    wr(ADDR_CTRL_A, 8'hb8);
    checkResult(selNow[LEFT_ALIGN_BIT]);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h51d6));
    for (int i = 0; i < 16; i++) vinCode[i] = 10'($urandom);
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rdReg(ADDR_POWER);
    check(rd, 8'h01);
    rdReg(8'h3c);
    check(rd, 8'h00);
    wr(ADDR_INPUT_SEL, 8'h45);
    wr(ADDR_POWER, 8'h00);
    repeat (3) @(negedge clock);
    check({refSelOut, chanSelOut}, 6'h00);
    wr(ADDR_CTRL_A, CTL_ON);
    repeat (3) @(negedge clock);
    check({analogEnable, refSelOut, chanSelOut}, 7'h55);
    selNow = 8'h45;
    wr(ADDR_CTRL_B, 8'h01);
    wr(ADDR_CTRL_A, 8'ha8);
    trigConv(1, l1);
    trigConv(1, l2);
    check(16'(l1 - l2), 16'd24);
    for (int i = 2; i < 8; i++) begin
      selNow = {refTab[i % 3], 1'($urandom), 1'b0, 4'($urandom)};
      wr(ADDR_INPUT_SEL, selNow);
      wr(ADDR_CTRL_B, 8'(i));
      h = holdCount;
      @(posedge clock);
      trigIn[i - 1] <= 1'b1;
      repeat (40) @(posedge clock);
      trigIn[i - 1] <= 1'b0;
      check(16'(holdCount - h), 16'h0);
      trigConv(i, l1);
      check(16'(l1), 16'(l2));
    end
    // a divide by four clock stretches every tick: 14 of them from edge to flag
    wr(ADDR_CTRL_A, 8'haa);
    trigConv(7, l1);
    check(16'(l1 - l2), 16'd28);
    wr(ADDR_CTRL_A, CTL_ON);
    for (int i = 0; i < 9; i++) begin
      selNow = {refTab[i % 3], 1'(i), 1'b0, 4'(i)};
      convert(selNow);
      checkResult(selNow[LEFT_ALIGN_BIT]);
    end
    // channel written mid-conversion waits for the next one
    expQ.push_back(expOf(8'h02));
    wr(ADDR_INPUT_SEL, 8'h02);
    wr(ADDR_CTRL_A, CTL_GO);
    wr(ADDR_INPUT_SEL, 8'h47);
    waitDone();
    wr(ADDR_CTRL_A, CTL_CLR);
    checkResult(1'b0);
    @(negedge clock);
    check({refSelOut, chanSelOut}, 6'h17);
    // locked bytes keep the older result
    convert(8'h03);
    rdReg(ADDR_RES_LOW);
    convert(8'h43);
    rdReg(ADDR_RES_HIGH);
    checkResult(1'b0);
    void'(expQ.pop_front());
    convert(8'h43);
    checkResult(1'b0);
    // free running needs a start, then keeps going with the flag left set
    wr(ADDR_CTRL_B, 8'h00);
    wr(ADDR_CTRL_A, 8'ha8);
    h = holdCount;
    repeat (100) @(posedge clock);
    check(16'(holdCount - h), 16'h0);
    wr(ADDR_CTRL_A, 8'he8);
    h = holdCount;
    repeat (200) @(posedge clock);
    check(16'(holdCount - h > 5), 16'h1);
    rdReg(ADDR_CTRL_A);
    check(rd[START_BIT], 1'b1);
    wr(ADDR_CTRL_A, CTL_ON);
    repeat (80) @(posedge clock);
    rdReg(ADDR_CTRL_A);
    check(rd[7:3], 5'h13);
    @(posedge clock);
    irqServiced <= 1'b1;
    @(posedge clock);
    irqServiced <= 1'b0;
    @(negedge clock);
    check(doneIrq, 1'b0);
    wr(ADDR_POWER, 8'h01);
    @(negedge clock);
    check(analogEnable, 1'b0);
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    print_verdict();
  end
endmodule
